// [hw/ppf_defines.vh]
// Constants for the parallel position feedback conversion engine
`ifndef PPF_DEFINES_VH
`define PPF_DEFINES_VH
`define PPF_TBL_WORDS 16
`define PPF_IDX_W 4
`define PPF_WORD_W 24
`define PPF_Y_BASE 2'b00
`define PPF_X_BASE 2'b01
`define PPF_CTRL_ADR 8'h80
`define PPF_STAT_ADR 8'h84
`define PPF_FMT_HI 23
`define PPF_FMT_LO 16
`define PPF_SRC_HI 15
`define PPF_SRC_LO 0
`define PPF_FAM_ZERO_BIT 23
`define PPF_FAM_ONE_BIT 21
`define PPF_XSPACE_BIT 22
`define PPF_FILT_BIT 20
`define PPF_UNSHIFT_BIT 19
`define PPF_SUM_BIT 16
`define PPF_FRAC_BITS 5
`define PPF_SHIFT_KEEP 19
`define PPF_CTRL_EN_BIT 0
`define PPF_CTRL_LEN_LO 8
`define PPF_CTRL_LEN_HI 12
`define PPF_CTRL_LEN_RST 5'h10
`define PPF_STAT_BUSY_BIT 0
`define PPF_STAT_OVR_BIT 1
`endif

// [hw/ppf_extend.v]
// Rollover extension of a masked parallel source word
`timescale 1ns/10ps
`default_nettype none
`include "ppf_defines.vh"
module ppf_extend
(
  input wire [23:0] raw_i,
  input wire [23:0] mask_i,
  input wire [23:0] old_raw_i,
  input wire [23:0] hi_i,
  input wire [23:0] lo_i,
  output wire [23:0] raw_o,
  output wire [23:0] hi_o,
  output wire [23:0] lo_o
);
  wire [23:0] delta;
  wire neg;
  wire [47:0] step;
  wire [47:0] sum;
  // Only enabled source bits count
  assign raw_o = raw_i & mask_i; // [R7]
  // Change modulo the mask width; upper half means backward wrap
  assign delta = (raw_o - old_raw_i) & mask_i; // [R7]
  assign neg = delta > (mask_i >> 1);
  assign step = neg ? ({24'h000000, delta} - {24'h000000, mask_i} - 48'h000000000001)
                    : {24'h000000, delta};
  assign sum = {hi_i, lo_i} + step;
  // High half is the sign-extended most significant word
  assign hi_o = sum[47:24]; // [R13]
  assign lo_o = sum[23:0];
endmodule
`default_nettype wire

// [hw/ppf_limit.v]
// Per-cycle change limiter for filtered entries
`timescale 1ns/10ps
`default_nettype none
module ppf_limit
(
  input wire en_i,
  input wire [23:0] target_i,
  input wire [23:0] prev_i,
  input wire [23:0] limit_i,
  output reg [23:0] out_o
);
  reg [23:0] diff;
  // Step toward target by at most the limit; the rest waits for later cycles
  always @*
  begin
    diff = target_i - prev_i;
    out_o = target_i;
    if (en_i && !diff[23] && (diff > limit_i)) // [R9]
      out_o = prev_i + limit_i; // [R10]
    else if (en_i && diff[23] && ((24'h000000 - diff) > limit_i)) // [R9]
      out_o = prev_i - limit_i; // [R10]
  end
endmodule
`default_nettype wire

// [hw/ppf_conv.v]
// Parallel position feedback conversion table engine with Wishbone slave
// Functional notes
// [R1] Format families 2x and 3x fetch the source from Y space, 6x and 7x from X space.
// [R2] The first setup word holds the format in bits 23..16 and source address in 15..0.
// [R3] With format bit 19 clear, masked data is shifted left five places (LSB = one count).
// [R4] With format bit 19 set, data is stored unshifted so one source LSB is 1/32 count.
// [R5] With format bit 16 set the previous entry's result is added; clear means no sum.
// [R6] Unfiltered entries take two table words, filtered three; word two is the bit mask.
// [R7] Only mask-enabled source bits are used and the mask width detects rollover.
// [R8] Shifted mode keeps only the low 19 source bits; unshifted takes all 24.
// [R9] Formats 3x and 7x limit the per-cycle change to the third setup word.
// [R10] An excess change is held back and applied later so no position is lost.
// [R11] Software sets the change limit a little above the fastest expected motion.
// [R12] The result goes to the X word paired with the entry's last setup word.
// [R13] The entry's first X word holds the sign-extended high word of the extended count.
// [R14] The result carries fraction in bits 4..0 and integer in bits 23..5.
// [R15] Every entry is processed once per servo cycle in table order before results are used; a tick that lands while the walk still runs starts no pass.
`timescale 1ns/10ps
`default_nettype none
`include "ppf_defines.vh"
module ppf_conv
(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire servo_tick_i,
  output wire src_req_o,
  output wire src_x_space_o,
  output wire [15:0] src_addr_o,
  input wire [23:0] src_data_i,
  input wire src_ack_i,
  output wire busy_o,
  output reg cycle_done_o
);
  localparam S_IDLE = 5'b00001;
  localparam S_SETUP = 5'b00010;
  localparam S_FETCH = 5'b00100;
  localparam S_CALC = 5'b01000;
  localparam S_DONE = 5'b10000;

  // Setup words (Y side) and result words (X side)
  reg [23:0] ytab_r [0:`PPF_TBL_WORDS-1];
  reg [23:0] xtab_r [0:`PPF_TBL_WORDS-1];
  // Private working state per entry
  reg [23:0] oldraw_r [0:`PPF_TBL_WORDS-1];
  reg [23:0] extlo_r [0:`PPF_TBL_WORDS-1];
  reg [23:0] filt_r [0:`PPF_TBL_WORDS-1];
  reg [`PPF_TBL_WORDS-1:0] primed_r;

  reg [4:0] state_r;
  // Walk state and table pointer; the pointer counts table words, not entries
  reg [4:0] ptr_r;

  // Copy of the entry under work, latched once so that a bus write in mid-entry
  // cannot move the fetch address or the mask halfway through
  reg [23:0] cfg_r;
  reg [23:0] mask_r;
  reg [23:0] lim_r;
  reg [23:0] data_r;
  reg [23:0] prev_res_r;

  // Software control and status
  reg ctrl_en_r;
  reg [4:0] ctrl_len_r;
  reg ovr_r;

  // Bus decode
  wire req;
  wire wr;
  wire [3:0] widx;

  // Table indices for the first, mask and limit words of an entry
  wire [3:0] pidx;
  wire [3:0] midx;
  wire [3:0] lidx;
  wire [3:0] last_idx;

  // Entry decode
  wire [23:0] setup_w;
  wire is_par;
  wire filt_w;
  wire [4:0] need_w;
  wire [4:0] room_w;
  wire primed;

  // Conversion datapath
  wire [23:0] raw_m;
  wire [23:0] ext_hi;
  wire [23:0] ext_lo;
  wire [23:0] target;
  wire [23:0] lim_out;
  wire [23:0] result;

  // Byte-lane write mask
  wire [23:0] wmask;
  integer i;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign widx = wb_adr_i[5:2];
  assign pidx = ptr_r[3:0];
  assign midx = pidx + 4'h1;
  assign lidx = pidx + 4'h2;

  // Entry decode from the current table word
  assign setup_w = ytab_r[pidx];
  assign is_par = !setup_w[`PPF_FAM_ZERO_BIT] && setup_w[`PPF_FAM_ONE_BIT]; // [R2]
  assign filt_w = setup_w[`PPF_FILT_BIT]; // [R9]
  assign need_w = filt_w ? 5'h03 : 5'h02; // [R6]
  assign room_w = ctrl_len_r - ptr_r;
  assign last_idx = cfg_r[`PPF_FILT_BIT] ? lidx : midx; // [R12]
  assign primed = primed_r[pidx];

  // Source fetch, held until the data port answers
  assign src_req_o = (state_r == S_FETCH);
  assign src_x_space_o = cfg_r[`PPF_XSPACE_BIT]; // [R1]
  assign src_addr_o = cfg_r[`PPF_SRC_HI:`PPF_SRC_LO]; // [R2]
  assign busy_o = (state_r != S_IDLE);

  // First sample of an entry seeds the count, so no jump on start-up
  ppf_extend u_ext
  (
    .raw_i(data_r),
    .mask_i(mask_r),
    .old_raw_i(primed ? oldraw_r[pidx] : (data_r & mask_r)),
    .hi_i(primed ? xtab_r[pidx] : 24'h000000),
    .lo_i(primed ? extlo_r[pidx] : (data_r & mask_r)),
    .raw_o(raw_m),
    .hi_o(ext_hi),
    .lo_o(ext_lo)
  );

  // Shifted: top five bits fall off, leaving 19 effective source bits
  assign target = cfg_r[`PPF_UNSHIFT_BIT] ? ext_lo // [R4] [R8]
                : {ext_lo[`PPF_SHIFT_KEEP-1:0], {`PPF_FRAC_BITS{1'b0}}}; // [R3] [R8] [R14]

  ppf_limit u_lim
  (
    .en_i(cfg_r[`PPF_FILT_BIT] && primed),
    .target_i(target),
    .prev_i(filt_r[pidx]),
    .limit_i(lim_r),
    .out_o(lim_out)
  );

  // Optional sum with the entry processed just before
  assign result = cfg_r[`PPF_SUM_BIT] ? (lim_out + prev_res_r) : lim_out; // [R5]

  // Byte-lane merge for setup word writes; lane 3 has no storage
  assign wmask = {{8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Setup table is written by software only
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (i = 0; i < `PPF_TBL_WORDS; i = i + 1)
        ytab_r[i] <= 24'h000000;
    end
    else if (wr && (wb_adr_i[7:6] == `PPF_Y_BASE))
    begin
      ytab_r[widx] <= (ytab_r[widx] & ~wmask) | (wb_dat_i[23:0] & wmask);
    end
  end

  // Control register and sticky overrun flag
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_en_r <= 1'b0;
      ctrl_len_r <= `PPF_CTRL_LEN_RST;
      ovr_r <= 1'b0;
    end
    else
    begin
      if (wr && (wb_adr_i == `PPF_CTRL_ADR))
      begin
        if (wb_sel_i[0])
          ctrl_en_r <= wb_dat_i[`PPF_CTRL_EN_BIT];
        if (wb_sel_i[1])
          ctrl_len_r <= wb_dat_i[`PPF_CTRL_LEN_HI:`PPF_CTRL_LEN_LO];
      end
      // A new tick while busy wins over a clear in the same cycle
      if (servo_tick_i && ctrl_en_r && (state_r != S_IDLE))
        ovr_r <= 1'b1;
      else if (wr && (wb_adr_i == `PPF_STAT_ADR) && wb_sel_i[0] && wb_dat_i[`PPF_STAT_OVR_BIT])
        ovr_r <= 1'b0;
    end
  end

  // Bus answer one cycle after the request, dropped the cycle after.
  // Gating the request with ack keeps a held strobe from being taken twice.
  // Unmapped reads answer zero so that software never stalls on a hole.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
      begin
        wb_dat_o <= 32'h00000000;
        if (wb_adr_i[7:6] == `PPF_Y_BASE)
          wb_dat_o <= {8'h00, ytab_r[widx]};
        else if (wb_adr_i[7:6] == `PPF_X_BASE)
          wb_dat_o <= {8'h00, xtab_r[widx]};
        else if (wb_adr_i == `PPF_CTRL_ADR)
          wb_dat_o <= {19'h00000, ctrl_len_r, 7'h00, ctrl_en_r};
        else if (wb_adr_i == `PPF_STAT_ADR)
          wb_dat_o <= {22'h000000, 3'h0, ptr_r, ovr_r, busy_o};
      end
    end
  end

  // Table walk: one pass per servo tick, entries in order.
  // Each parallel entry costs a setup cycle, the fetch wait and a calc cycle,
  // so a slow source stretches the pass; a tick that lands while the walk
  // still runs is dropped and only flagged as overrun.
  // Words of other formats are stepped over one at a time.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= S_IDLE;
      ptr_r <= 5'h00;
      cfg_r <= 24'h000000;
      mask_r <= 24'h000000;
      lim_r <= 24'h000000;
      data_r <= 24'h000000;
      prev_res_r <= 24'h000000;
      cycle_done_o <= 1'b0;
    end
    else
    begin
      cycle_done_o <= 1'b0;
      case (state_r)
        // Wait for a servo tick with the engine enabled
        S_IDLE:
        begin
          if (servo_tick_i && ctrl_en_r)
          begin
            ptr_r <= 5'h00; // [R15]
            prev_res_r <= 24'h000000;
            state_r <= S_SETUP;
          end
        end

        // Decode the word at the pointer; skip what does not fit
        S_SETUP:
        begin
          if (ptr_r >= ctrl_len_r)
            state_r <= S_DONE;
          else if (is_par && (room_w >= need_w))
          begin
            cfg_r <= setup_w;
            mask_r <= ytab_r[midx]; // [R6] [R7]
            lim_r <= filt_w ? ytab_r[lidx] : 24'h000000; // [R9]
            state_r <= S_FETCH;
          end
          else
            ptr_r <= ptr_r + 5'h01; // Other formats are not handled here
        end

        // Hold the request until the source port answers
        S_FETCH:
        begin
          if (src_ack_i)
          begin
            data_r <= src_data_i;
            state_r <= S_CALC;
          end
        end

        // Result is written by the update process in this same cycle
        S_CALC:
        begin
          prev_res_r <= result; // [R5]
          ptr_r <= ptr_r + (cfg_r[`PPF_FILT_BIT] ? 5'h03 : 5'h02); // [R6] [R15]
          state_r <= S_SETUP;
        end

        // Whole table done for this tick
        S_DONE:
        begin
          cycle_done_o <= 1'b1; // [R15]
          state_r <= S_IDLE;
        end

        // Any stray code falls back to idle
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // Result and working-state update at the end of each entry.
  // The low word of the extended count and the filter state stay private;
  // software sees only the high word and the converted result.
  // The first pass after reset only seeds these, so no false jump appears.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      primed_r <= {`PPF_TBL_WORDS{1'b0}};
      for (i = 0; i < `PPF_TBL_WORDS; i = i + 1)
      begin
        xtab_r[i] <= 24'h000000;
        oldraw_r[i] <= 24'h000000;
        extlo_r[i] <= 24'h000000;
        filt_r[i] <= 24'h000000;
      end
    end
    else if (state_r == S_CALC)
    begin
      primed_r[pidx] <= 1'b1;
      oldraw_r[pidx] <= raw_m; // [R7]
      extlo_r[pidx] <= ext_lo;
      filt_r[pidx] <= lim_out; // [R10]
      xtab_r[pidx] <= ext_hi; // [R13]
      xtab_r[last_idx] <= result; // [R12] [R14]
    end
  end
endmodule
`default_nettype wire

// [verification/ppf_conv_chk.sv]
// Port-level checks for the conversion engine
`timescale 1ns/10ps
`default_nettype none
module ppf_conv_chk
(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire src_req_o,
  input wire src_ack_i,
  input wire src_x_space_o,
  input wire [15:0] src_addr_o,
  input wire busy_o,
  input wire cycle_done_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Fetch steps: a waiting request, then the taken answer
  sequence s_wait;
    src_req_o && !src_ack_i;
  endsequence
  sequence s_taken;
    src_req_o && src_ack_i;
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("bus ack without request");
  AST_RD_TOP: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h00)
    else $error("read data above bit 23 not zero");
  AST_REQ_HOLD: assert property (s_wait |=> src_req_o && $stable(src_addr_o))
    else $error("fetch address moved before answer");
  AST_SPACE_HOLD: assert property (s_wait |=> $stable(src_x_space_o))
    else $error("fetch space moved before answer");
  AST_REQ_DROP: assert property (s_taken |=> !src_req_o)
    else $error("fetch request held after answer");
  AST_REQ_BUSY: assert property (src_req_o |-> busy_o)
    else $error("fetch outside table walk");
  AST_DONE_ONE: assert property (cycle_done_o |=> !cycle_done_o)
    else $error("done pulse longer than one cycle");
  AST_DONE_QUIET: assert property (cycle_done_o |-> !src_req_o)
    else $error("done while still fetching");
endmodule
bind ppf_conv ppf_conv_chk i_ppf_conv_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .src_req_o, .src_ack_i, .src_x_space_o, .src_addr_o,
  .busy_o, .cycle_done_o);
`default_nettype wire

// [verification/ppf_src_model.sv]
// Far-side source port: answers each fetch after a set lag
`timescale 1ns/10ps
`default_nettype none
module ppf_src_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic x_i,
  input wire logic [3:0] lag_i,
  input wire logic [23:0] y_word_i,
  input wire logic [23:0] x_word_i,
  output logic ack_o,
  output logic [23:0] data_o
);
  logic [3:0] wait_r;
  // One-cycle answer; released data inverts so a stale word never matches
  always @(posedge clk_i)
  begin
    if (rst_i || ack_o)
    begin
      ack_o <= 1'b0;
      wait_r <= 4'h0;
      data_o <= rst_i ? 24'h000000 : ~data_o;
    end
    else if (req_i && wait_r == lag_i)
    begin
      ack_o <= 1'b1;
      data_o <= x_i ? x_word_i : y_word_i;
    end
    else if (req_i)
      wait_r <= wait_r + 4'h1;
  end
endmodule
`default_nettype wire

// [verification/ppf_conv_bench.sv]
// Testbench for the parallel position conversion engine
`timescale 1ns/10ps
`default_nettype none
module ppf_conv_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic tick = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h00000000;
  logic [3:0] lag = 4'h0;
  logic [23:0] y_word = 24'h000000;
  logic [23:0] x_word = 24'h000000;
  logic [16:0] fetch_seen = 17'h00000;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, src_req_o, src_x_space_o, src_ack_i, busy_o, cycle_done_o;
  wire [15:0] src_addr_o;
  wire [23:0] src_data_i;
  integer err_total = 0;
  integer checks = 0;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  ppf_conv i_ppf_conv (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .servo_tick_i(tick), .src_req_o(src_req_o),
    .src_x_space_o(src_x_space_o), .src_addr_o(src_addr_o), .src_data_i(src_data_i),
    .src_ack_i(src_ack_i), .busy_o(busy_o), .cycle_done_o(cycle_done_o));
  ppf_src_model i_ppf_src_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(src_req_o),
    .x_i(src_x_space_o), .lag_i(lag), .y_word_i(y_word), .x_word_i(x_word),
    .ack_o(src_ack_i), .data_o(src_data_i));
  // Space and address of the last taken fetch
  always @(posedge clk_i)
    if (src_req_o && src_ack_i)
      fetch_seen <= {src_x_space_o, src_addr_o};
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle; a read compares its data against d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (!w) chk(wb_dat_o, d);
    cyc <= 1'b0;
    if (n >= 20) err_total++;
  endtask
  // Reset, then one entry at word 0 and the control word
  task automatic setup(input logic [7:0] f, input logic [23:0] m, input logic [23:0] l,
    input logic [4:0] len);
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, 8'h00, {8'h00, f, 16'hFFD0});
    bus(1'b1, 8'h04, {8'h00, m});
    bus(1'b1, 8'h08, {8'h00, l});
    bus(1'b1, `PPF_CTRL_ADR, {19'h0, len, 8'h01});
  endtask
  // One servo cycle with the given source words; waits for the done pulse
  task automatic servo(input logic [23:0] yv, input logic [23:0] xv);
    integer n;
    n = 0;
    @(posedge clk_i);
    y_word <= yv;
    x_word <= xv;
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    while (cycle_done_o !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300) err_total++;
  endtask
  task automatic report_and_stop;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    setup(8'h20, 24'h000FFF, 24'h000000, 5'd2);
    bus(1'b0, 8'hFC, 32'h00000000);
    servo(24'h000FF0, 24'h000555);
    bus(1'b0, 8'h44, 32'h0001FE00);
    bus(1'b0, `PPF_STAT_ADR, 32'h00000008);
    servo(24'h000010, 24'h000555);
    bus(1'b0, 8'h44, 32'h00020200);
    // Slow source, backward wrap
    lag <= 4'h3;
    setup(8'h20, 24'h000FFF, 24'h000000, 5'd2);
    servo(24'h000010, 24'h000555);
    servo(24'h000FF0, 24'h000555);
    bus(1'b0, 8'h44, 32'h00FFFE00);
    bus(1'b0, 8'h40, 32'h00FFFFFF);
    setup(8'h68, 24'hFFFFFF, 24'h000000, 5'd2);
    servo(24'h111111, 24'hABCDEF);
    bus(1'b0, 8'h44, 32'h00ABCDEF);
    chk({15'h0000, fetch_seen}, 32'h0001FFD0);
    setup(8'h20, 24'hFFFFFF, 24'h000000, 5'd2);
    servo(24'hF80001, 24'h000000);
    bus(1'b0, 8'h44, 32'h00000020);
    // Step of 0x80 against a limit of 0x40, half the step, so the rest lands on the next cycle
    setup(8'h30, 24'h000FFF, 24'h000040, 5'd3);
    servo(24'h000100, 24'h000000);
    servo(24'h000104, 24'h000000);
    bus(1'b0, 8'h48, 32'h00002040);
    servo(24'h000104, 24'h000000);
    bus(1'b0, 8'h48, 32'h00002080);
    // Second entry at word 2 sums the first
    setup(8'h20, 24'h000FFF, 24'h21FFD1, 5'd4);
    bus(1'b1, 8'h0C, 32'h00000FFF);
    servo(24'h000100, 24'h000000);
    servo(24'h000100, 24'h000000);
    bus(1'b0, 8'h4C, 32'h00004000);
    bus(1'b0, 8'h44, 32'h00002000);
    chk({15'h0000, fetch_seen}, 32'h0000FFD1);
    report_and_stop;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #300000;
    err_total++;
    report_and_stop;
  end
endmodule
`default_nettype wire
